//--- rcoc_defines.vh
// Register offsets, field positions, reset values and codes of the channel override block.
`ifndef RCOC_DEFINES_VH
`define RCOC_DEFINES_VH

`define RCOC_ADDR_BOOST_CUR      8'h03
`define RCOC_ADDR_CAP_CODE_ONE   8'h08
`define RCOC_ADDR_OVR_EN         8'h09
`define RCOC_ADDR_CAP_CODE_TWO   8'h0b
`define RCOC_ADDR_STAGE_LIMIT    8'h13
`define RCOC_ADDR_SD_FORCE       8'h14
`define RCOC_ADDR_OUT_SEL        8'h1e
`define RCOC_ADDR_RATE_SUB       8'h2f
`define RCOC_ADDR_ADAPT_MODE     8'h31
`define RCOC_ADDR_SEARCH_MODE    8'h36
`define RCOC_ADDR_BOOST_LOW      8'h3a
`define RCOC_ADDR_RAW_RESEARCH   8'h3f
`define RCOC_ADDR_BOOST_SEC      8'h40

`define RCOC_RST_OUT_SEL         8'he0
`define RCOC_RST_ZERO            8'h00

`define RCOC_BIT_STAGE_LIMIT     2
`define RCOC_BIT_QCLK_EN_A       4
`define RCOC_BIT_QCLK_EN_B       0
`define RCOC_BIT_MUX_OVR         5
`define RCOC_BIT_CAP_OVR         7
`define RCOC_BIT_RAW_NO_RESEARCH 7
`define RCOC_BIT_SD_FORCE_HI     7
`define RCOC_BIT_SD_FORCE_LO     6
`define RCOC_SEL_HI              7
`define RCOC_SEL_LO              5
`define RCOC_ADAPT_HI            6
`define RCOC_ADAPT_LO            5
`define RCOC_SRCH_HI             5
`define RCOC_SRCH_LO             4
`define RCOC_RATE_HI             7
`define RCOC_RATE_LO             4
`define RCOC_CAP_HI              4
`define RCOC_CAP_LO              0

`define RCOC_SRCH_CAP_FIRST      2'b11

`define RCOC_OSEL_RAW            3'h0
`define RCOC_OSEL_RETIMED        3'h1
`define RCOC_OSEL_ICLK           3'h2
`define RCOC_OSEL_QCLK           3'h3
`define RCOC_OSEL_PRBS           3'h4
`define RCOC_OSEL_OSC10          3'h5
`define RCOC_OSEL_INVALID        3'h6
`define RCOC_OSEL_MUTE           3'h7

`define RCOC_DIV_1               3'h0
`define RCOC_DIV_4               3'h2
`define RCOC_DIV_8               3'h3

`endif

//--- rcoc_fifo.v
// Synchronous FIFO with valid and ready on both sides and registered flags.
`timescale 1ns/1ps
`default_nettype none
module rcoc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_n_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  reg             not_full_reg;
  reg             not_empty_reg;
  wire            push;
  wire            pop;
  wire [AW:0]     count_next;

  assign push        = in_valid_i & not_full_reg;
  assign pop         = out_ready_i & not_empty_reg;
  assign in_ready_o  = not_full_reg;
  assign out_valid_o = not_empty_reg;
  assign out_data_o  = mem[rd_ptr_reg];
  assign count_next  = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg    <= {AW{1'b0}};
      rd_ptr_reg    <= {AW{1'b0}};
      count_reg     <= {(AW+1){1'b0}};
      not_full_reg  <= 1'b1;
      not_empty_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      count_reg     <= count_next;
      not_full_reg  <= (count_next != DEPTH);
      not_empty_reg <= (count_next != {(AW+1){1'b0}});
    end
  end
endmodule
`default_nettype wire

//--- rcoc_top.v
// Per-channel boost, coarse tuning and output multiplexer override logic of a retimer.
//
// How it works
// - Current boost register; controller write replaces it.
// - Separate bit puts last stage in limiting.
// - Lock loss restarts lock and adaptation sequence.
// - Adapt mode zero keeps boost values untouched.
// - Relock search starts at divide 8 when subrate bits are set, else at divide 1.
// - Divide 4 and 8 use low-rate boost.
// - Controller presets boosts; relock keeps them unchanged.
// - Search mode 11 runs coarse tuning search first when tuning codes are not overridden.
// - Rate and subrate fields set search range.
// - Two manual tuning codes, used only when enabled.
// - Override alternates code one div 8, code two div 1.
// - Default output muted unless signal present and locked.
// - Three-bit select field encodes the output source.
// - Quadrature clock needs two extra enable bits.
// - Without override, select applies only present-but-unlocked.
// - With override, output follows select field while signal present or raw held.
// - Raw mode bit keeps output from powering down when override selects raw.
// - No signal powers channel down and mutes output.
// - Force bits 10 force signal detect; 00 automatic.
// - Clocks and pattern follow input when locked.
// - Internal 10 MHz clock selectable under override.
`timescale 1ns/1ps
`default_nettype none
`include "rcoc_defines.vh"
module rcoc_top #(
  parameter WIDTH      = 8,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_n_i,
  // Management register port
  input  wire [7:0]       reg_addr_i,
  input  wire [7:0]       reg_wdata_i,
  input  wire             reg_wr_i,
  input  wire             reg_rd_i,
  output wire [7:0]       reg_rdata_o,
  // Analog front end status
  input  wire             sig_detect_i,
  input  wire             cdr_lock_i,
  input  wire             lock_try_fail_i,
  input  wire             cap_search_done_i,
  input  wire             adapt_done_i,
  input  wire [7:0]       adapt_boost_i,
  // Analog front end control
  output wire             channel_en_o,
  output wire [7:0]       boost_applied_o,
  output wire             stage_limit_o,
  output wire [2:0]       vco_div_o,
  output wire [4:0]       cap_code_o,
  output wire             cap_search_o,
  output wire [3:0]       search_range_o,
  output wire             vco_free_run_o,
  // Recovered data stream in
  input  wire             rt_valid_i,
  output wire             rt_ready_o,
  input  wire [WIDTH-1:0] rt_data_i,
  // Other sources of the output multiplexer
  input  wire [WIDTH-1:0] raw_data_i,
  input  wire [WIDTH-1:0] prbs_data_i,
  input  wire [WIDTH-1:0] iclk_pat_i,
  input  wire [WIDTH-1:0] qclk_pat_i,
  input  wire [WIDTH-1:0] osc10_pat_i,
  // Output stream
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire [2:0]       out_src_o
);
  localparam ST_IDLE   = 2'd0;
  localparam ST_CAPSRC = 2'd1;
  localparam ST_TRY    = 2'd2;
  localparam ST_LOCKED = 2'd3;

  reg [7:0]       boost_cur_reg;
  reg [7:0]       cap_one_reg;
  reg [7:0]       ovr_en_reg;
  reg [7:0]       cap_two_reg;
  reg [7:0]       stage_lim_reg;
  reg [7:0]       sd_force_reg;
  reg [7:0]       out_sel_reg;
  reg [7:0]       rate_sub_reg;
  reg [7:0]       adapt_reg;
  reg [7:0]       search_reg;
  reg [7:0]       boost_low_reg;
  reg [7:0]       raw_res_reg;
  reg [7:0]       boost_sec_reg;
  reg [7:0]       rdata_reg;
  reg [1:0]       state_reg;
  reg [2:0]       div_reg;
  reg             alt_reg;
  reg             chan_en_reg;
  reg [7:0]       boost_app_reg;
  reg             limit_reg;
  reg [4:0]       cap_reg;
  reg             cap_srch_reg;
  reg             free_run_reg;
  reg             out_valid_reg;
  reg [WIDTH-1:0] out_data_reg;
  reg [2:0]       out_src_reg;
  reg [7:0]       rdata_next;
  reg [2:0]       src_next;
  reg [WIDTH-1:0] word_next;

  wire             cap_ovr;
  wire             mux_ovr;
  wire             sd_eff;
  wire             raw_hold;
  wire             low_div;
  wire [2:0]       sel_field;
  wire [2:0]       start_div;
  wire             fifo_valid;
  wire             fifo_pop;
  wire [WIDTH-1:0] fifo_data;
  wire             out_take;

  assign cap_ovr   = ovr_en_reg[`RCOC_BIT_CAP_OVR];
  assign mux_ovr   = ovr_en_reg[`RCOC_BIT_MUX_OVR];
  assign sel_field = out_sel_reg[`RCOC_SEL_HI:`RCOC_SEL_LO];
  assign sd_eff    = (sd_force_reg[`RCOC_BIT_SD_FORCE_HI:`RCOC_BIT_SD_FORCE_LO] == 2'b10) |
                     sig_detect_i;
  assign raw_hold  = raw_res_reg[`RCOC_BIT_RAW_NO_RESEARCH] & mux_ovr &
                     (sel_field == `RCOC_OSEL_RAW);
  assign start_div = (rate_sub_reg[5:4] != 2'b00) ? `RCOC_DIV_8 : `RCOC_DIV_1;
  assign low_div   = (div_reg == `RCOC_DIV_4) | (div_reg == `RCOC_DIV_8);

  // Register read data is captured on the clock edge that samples the read strobe.
  always @* begin
    case (reg_addr_i)
      `RCOC_ADDR_BOOST_CUR:    rdata_next = boost_cur_reg;
      `RCOC_ADDR_CAP_CODE_ONE: rdata_next = cap_one_reg;
      `RCOC_ADDR_OVR_EN:       rdata_next = ovr_en_reg;
      `RCOC_ADDR_CAP_CODE_TWO: rdata_next = cap_two_reg;
      `RCOC_ADDR_STAGE_LIMIT:  rdata_next = stage_lim_reg;
      `RCOC_ADDR_SD_FORCE:     rdata_next = sd_force_reg;
      `RCOC_ADDR_OUT_SEL:      rdata_next = out_sel_reg;
      `RCOC_ADDR_RATE_SUB:     rdata_next = rate_sub_reg;
      `RCOC_ADDR_ADAPT_MODE:   rdata_next = adapt_reg;
      `RCOC_ADDR_SEARCH_MODE:  rdata_next = search_reg;
      `RCOC_ADDR_BOOST_LOW:    rdata_next = boost_low_reg;
      `RCOC_ADDR_RAW_RESEARCH: rdata_next = raw_res_reg;
      `RCOC_ADDR_BOOST_SEC:    rdata_next = boost_sec_reg;
      default:                 rdata_next = 8'h00;
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_one_reg   <= `RCOC_RST_ZERO;
      ovr_en_reg    <= `RCOC_RST_ZERO;
      cap_two_reg   <= `RCOC_RST_ZERO;
      stage_lim_reg <= `RCOC_RST_ZERO;
      sd_force_reg  <= `RCOC_RST_ZERO;
      out_sel_reg   <= `RCOC_RST_OUT_SEL;
      rate_sub_reg  <= `RCOC_RST_ZERO;
      adapt_reg     <= `RCOC_RST_ZERO;
      search_reg    <= `RCOC_RST_ZERO;
      boost_low_reg <= `RCOC_RST_ZERO;
      raw_res_reg   <= `RCOC_RST_ZERO;
      boost_sec_reg <= `RCOC_RST_ZERO;
      rdata_reg     <= `RCOC_RST_ZERO;
    end else begin
      if (reg_rd_i) begin
        rdata_reg <= rdata_next;
      end
      if (reg_wr_i) begin
        case (reg_addr_i)
          `RCOC_ADDR_CAP_CODE_ONE: cap_one_reg   <= reg_wdata_i;
          `RCOC_ADDR_OVR_EN:       ovr_en_reg    <= reg_wdata_i;
          `RCOC_ADDR_CAP_CODE_TWO: cap_two_reg   <= reg_wdata_i;
          `RCOC_ADDR_STAGE_LIMIT:  stage_lim_reg <= reg_wdata_i;
          `RCOC_ADDR_SD_FORCE:     sd_force_reg  <= reg_wdata_i;
          `RCOC_ADDR_OUT_SEL:      out_sel_reg   <= reg_wdata_i;
          `RCOC_ADDR_RATE_SUB:     rate_sub_reg  <= reg_wdata_i;
          `RCOC_ADDR_ADAPT_MODE:   adapt_reg     <= reg_wdata_i;
          `RCOC_ADDR_SEARCH_MODE:  search_reg    <= reg_wdata_i;
          `RCOC_ADDR_BOOST_LOW:    boost_low_reg <= reg_wdata_i;
          `RCOC_ADDR_RAW_RESEARCH: raw_res_reg   <= reg_wdata_i;
          `RCOC_ADDR_BOOST_SEC:    boost_sec_reg <= reg_wdata_i;
          default:                 ;
        endcase
      end
    end
  end

  // Lock search sequencer. The current boost register is written by the controller, the
  // sequencer and adaptation; a controller write wins so it is never lost.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg     <= ST_IDLE;
      div_reg       <= `RCOC_DIV_1;
      alt_reg       <= 1'b0;
      cap_srch_reg  <= 1'b0;
      boost_cur_reg <= `RCOC_RST_ZERO;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          cap_srch_reg <= 1'b0;
          alt_reg      <= 1'b0;
          if (sd_eff) begin
            div_reg <= start_div;
            if (!cap_ovr &&
                search_reg[`RCOC_SRCH_HI:`RCOC_SRCH_LO] == `RCOC_SRCH_CAP_FIRST) begin
              cap_srch_reg <= 1'b1;
              state_reg    <= ST_CAPSRC;
            end else begin
              state_reg <= ST_TRY;
            end
          end
        end
        ST_CAPSRC: begin
          if (!sd_eff) begin
            state_reg <= ST_IDLE;
          end else if (cap_search_done_i) begin
            cap_srch_reg <= 1'b0;
            state_reg    <= ST_TRY;
          end
        end
        ST_TRY: begin
          if (!sd_eff) begin
            state_reg <= ST_IDLE;
          end else if (cdr_lock_i) begin
            state_reg <= ST_LOCKED;
          end else if (lock_try_fail_i) begin
            if (cap_ovr) begin
              alt_reg <= ~alt_reg;
              div_reg <= alt_reg ? `RCOC_DIV_8 : `RCOC_DIV_1;
            end else begin
              div_reg <= (div_reg == `RCOC_DIV_1) ? start_div : div_reg - 3'd1;
            end
          end
        end
        ST_LOCKED: begin
          if (!sd_eff || !cdr_lock_i) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (reg_wr_i && reg_addr_i == `RCOC_ADDR_BOOST_CUR) begin
        boost_cur_reg <= reg_wdata_i;
      end else if (state_reg == ST_TRY && low_div) begin
        boost_cur_reg <= boost_low_reg;
      end else if (adapt_done_i &&
                   adapt_reg[`RCOC_ADAPT_HI:`RCOC_ADAPT_LO] != 2'b00) begin
        boost_cur_reg <= adapt_boost_i;
      end
    end
  end

  // Relock uses only controller-written boosts in adapt mode zero.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chan_en_reg   <= 1'b0;
      boost_app_reg <= `RCOC_RST_ZERO;
      limit_reg     <= 1'b0;
      cap_reg       <= 5'h00;
      free_run_reg  <= 1'b1;
    end else begin
      chan_en_reg   <= sd_eff | raw_hold;
      boost_app_reg <= (state_reg == ST_TRY && low_div) ? boost_low_reg : boost_cur_reg;
      limit_reg     <= stage_lim_reg[`RCOC_BIT_STAGE_LIMIT];
      if (cap_ovr) begin
        cap_reg <= alt_reg ? cap_two_reg[`RCOC_CAP_HI:`RCOC_CAP_LO] :
                             cap_one_reg[`RCOC_CAP_HI:`RCOC_CAP_LO];
      end else begin
        cap_reg <= 5'h00;
      end
      // Locked sources follow input
      // Lock or signal loss frees the VCO on the same edge the sequencer leaves lock.
      free_run_reg  <= !(state_reg == ST_LOCKED && sd_eff && cdr_lock_i);
    end
  end

  // Output source choice.
  always @* begin
    if (mux_ovr) begin
      src_next = sel_field;
    end else if (!sd_eff) begin
      src_next = `RCOC_OSEL_MUTE;
    end else if (state_reg == ST_LOCKED) begin
      src_next = `RCOC_OSEL_RETIMED;
    end else begin
      src_next = sel_field;
    end
    if (src_next == `RCOC_OSEL_OSC10 && !mux_ovr) begin
      src_next = `RCOC_OSEL_MUTE;
    end
    if (src_next == `RCOC_OSEL_QCLK &&
        !(ovr_en_reg[`RCOC_BIT_QCLK_EN_A] && out_sel_reg[`RCOC_BIT_QCLK_EN_B])) begin
      src_next = `RCOC_OSEL_MUTE;
    end
    if (!(sd_eff | raw_hold)) begin
      src_next = `RCOC_OSEL_MUTE;
    end
    case (src_next)
      `RCOC_OSEL_RAW:     word_next = raw_data_i;
      `RCOC_OSEL_RETIMED: word_next = fifo_data;
      `RCOC_OSEL_ICLK:    word_next = iclk_pat_i;
      `RCOC_OSEL_QCLK:    word_next = qclk_pat_i;
      `RCOC_OSEL_PRBS:    word_next = prbs_data_i;
      `RCOC_OSEL_OSC10:   word_next = osc10_pat_i;
      default:            word_next = {WIDTH{1'b0}};
    endcase
  end

  // The recovered stream keeps draining whatever source is shown, so the
  // word rate at the output always tracks the input.
  assign out_take = ~out_valid_reg | out_ready_i;
  assign fifo_pop = out_take;

  rcoc_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (rt_valid_i),
    .in_ready_o  (rt_ready_o),
    .in_data_i   (rt_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= {WIDTH{1'b0}};
      out_src_reg   <= `RCOC_OSEL_MUTE;
    end else if (out_take) begin
      out_valid_reg <= fifo_valid;
      out_data_reg  <= word_next;
      out_src_reg   <= src_next;
    end
  end

  assign reg_rdata_o     = rdata_reg;
  assign channel_en_o    = chan_en_reg;
  assign boost_applied_o = boost_app_reg;
  assign stage_limit_o   = limit_reg;
  assign vco_div_o       = div_reg;
  assign cap_code_o      = cap_reg;
  assign cap_search_o    = cap_srch_reg;
  assign search_range_o  = rate_sub_reg[`RCOC_RATE_HI:`RCOC_RATE_LO];
  assign vco_free_run_o  = free_run_reg;
  assign out_valid_o     = out_valid_reg;
  assign out_data_o      = out_data_reg;
  assign out_src_o       = out_src_reg;
endmodule
`default_nettype wire

//--- rcoc_chk.sv
// Port-level assertions of the channel override block.
`timescale 1ns/1ps
`default_nettype none
module rcoc_chk #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic             clk_i,
  input wire logic             rst_n_i,
  // Register port
  input wire logic [7:0]       reg_addr_i,
  input wire logic [7:0]       reg_wdata_i,
  input wire logic             reg_wr_i,
  input wire logic             reg_rd_i,
  input wire logic [7:0]       reg_rdata_o,
  // Front end
  input wire logic             sig_detect_i,
  input wire logic             cdr_lock_i,
  input wire logic             stage_limit_o,
  input wire logic [4:0]       cap_code_o,
  input wire logic [3:0]       search_range_o,
  input wire logic             vco_free_run_o,
  // Output stream
  input wire logic             out_valid_o,
  input wire logic             out_ready_i,
  input wire logic [WIDTH-1:0] out_data_o,
  input wire logic [2:0]       out_src_o
);
  // Shadow copies load on the same edge as the design's registers.
  logic [7:0] m09_reg;
  logic [7:0] m13_reg;
  logic [7:0] m1e_reg;
  logic [7:0] m2f_reg;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      m09_reg <= 8'h00;
      m13_reg <= 8'h00;
      m1e_reg <= 8'he0;
      m2f_reg <= 8'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h09) m09_reg <= reg_wdata_i;
      if (reg_addr_i == 8'h13) m13_reg <= reg_wdata_i;
      if (reg_addr_i == 8'h1e) m1e_reg <= reg_wdata_i;
      if (reg_addr_i == 8'h2f) m2f_reg <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_mute;
    out_valid_o && out_src_o == 3'h7 |-> out_data_o == '0;
  endproperty
  a_mute: assert property (p_mute) else $error("muted word not zero");
  property p_hold;
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o) && $stable(out_src_o);
  endproperty
  a_hold: assert property (p_hold) else $error("output word moved while stalled");
  property p_range;
    search_range_o == m2f_reg[7:4];
  endproperty
  a_range: assert property (p_range) else $error("search range differs");
  property p_cap;
    !m09_reg[7] && !$past(m09_reg[7]) |-> cap_code_o == 5'h00;
  endproperty
  a_cap: assert property (p_cap) else $error("tuning code without override");
  property p_limit;
    m13_reg[2] == $past(m13_reg[2]) |-> stage_limit_o == m13_reg[2];
  endproperty
  a_limit: assert property (p_limit) else $error("limit stage differs");
  property p_rd;
    reg_rd_i && !reg_wr_i && reg_addr_i == 8'h1e |=> reg_rdata_o == $past(m1e_reg);
  endproperty
  a_rd: assert property (p_rd) else $error("select register read wrong");
  property p_lock;
    (sig_detect_i && cdr_lock_i) [*4] |=> !vco_free_run_o;
  endproperty
  a_lock: assert property (p_lock) else $error("free run while locked");
  property p_unlock;
    !cdr_lock_i |=> vco_free_run_o;
  endproperty
  a_unlock: assert property (p_unlock) else $error("no free run when unlocked");
endmodule
bind rcoc_top rcoc_chk #(.WIDTH(WIDTH)) u_chk (.*);
`default_nettype wire

//--- rcoc_sink.sv
// Output-side sink that stalls on request and otherwise takes words at random.
`timescale 1ns/1ps
`default_nettype none
module rcoc_sink (
  // Clock and control
  input  wire logic clk_i,
  input  wire logic stall_i,
  // Stream handshake
  output var  logic ready_o
);
  initial ready_o = 1'b0;
  // Ready moves just after the edge so the design samples a settled level.
  always @(posedge clk_i) begin
    #1;
    ready_o = !stall_i && ($urandom % 4 != 0);
  end
endmodule
`default_nettype wire

//--- retimer_channel_override_control_tb_top.sv
// Self-checking bench of the channel override block.
`timescale 1ns/1ps
`default_nettype none
module retimer_channel_override_control_tb_top;
  logic            clk_i = 1'b0;
  logic            rst_n_i = 1'b0;
  logic [7:0]      reg_addr_i = 8'h00, reg_wdata_i = 8'h00, adapt_boost_i = 8'h00;
  logic            reg_wr_i = 1'b0, reg_rd_i = 1'b0, sig_detect_i = 1'b0, cdr_lock_i = 1'b0;
  logic            lock_try_fail_i = 1'b0, cap_search_done_i = 1'b0, adapt_done_i = 1'b0;
  logic            rt_valid_i = 1'b0, out_ready_i, stall = 1'b1;
  logic [7:0]      rt_data_i = 8'h00, raw_data_i = 8'h00, prbs_data_i = 8'h00;
  logic [7:0]      iclk_pat_i = 8'h00, qclk_pat_i = 8'h00, osc10_pat_i = 8'h00;
  wire logic [7:0] reg_rdata_o, boost_applied_o, out_data_o;
  wire logic       channel_en_o, stage_limit_o, cap_search_o, vco_free_run_o;
  wire logic       rt_ready_o, out_valid_o;
  wire logic [2:0] vco_div_o, out_src_o;
  wire logic [4:0] cap_code_o;
  wire logic [3:0] search_range_o;
  int              mismatches = 0, checked = 0;
  logic [7:0]      exp_q[$];
  logic [7:0]      w, v, c1, c2;
  rcoc_top dut (.*);
  rcoc_sink sink (.clk_i(clk_i), .stall_i(stall), .ready_o(out_ready_i));
  always #12.5 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    step(1);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    step(1);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    step(1);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask
  task automatic pulse(ref logic s);
    step(1);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(2);
  endtask
  // Source 8 stands for the quadrature clock once both enables are set.
  function automatic logic [7:0] pick(input int s, input logic [7:0] d);
    case (s)
      0: pick = raw_data_i;
      1: pick = d;
      2: pick = iclk_pat_i;
      4: pick = prbs_data_i;
      5: pick = osc10_pat_i;
      8: pick = qclk_pat_i;
      default: pick = 8'h00;
    endcase
  endfunction
  task automatic drain;
    for (int t = 0; t < 200 && exp_q.size() > 0; t++) step(1);
    chk("pending", 8'h00, 8'(exp_q.size()));
  endtask
  task automatic push(input int s);
    int t;
    step(1);
    rt_valid_i = 1'b1;
    rt_data_i = 8'($urandom);
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (rt_ready_o !== 1'b1 && t < 50);
    exp_q.push_back(pick(s, rt_data_i));
    #1 rt_valid_i = 1'b0;
    drain;
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (rst_n_i && out_valid_o === 1'b1 && out_ready_i) begin
      if (exp_q.size() == 0)
        chk("extra_word", 8'h00, 8'h01);
      else
        chk("out_data", exp_q.pop_front(), out_data_o);
    end
  end
  initial begin
    #(25 * 20000);
    mismatches++;
    stop_test;
  end
  initial begin
    logic [7:0] regs [13] = '{8'h03, 8'h08, 8'h09, 8'h0b, 8'h13, 8'h14, 8'h1e,
                              8'h2f, 8'h31, 8'h36, 8'h3a, 8'h3f, 8'h40};
    int n;
    void'($urandom(65));
    step(20);
    rst_n_i = 1'b1;
    foreach (regs[i]) begin
      rd(regs[i], v);
      chk("reset_val", (regs[i] == 8'h1e) ? 8'he0 : 8'h00, v);
      w = 8'($urandom);
      wr(regs[i], w);
      rd(regs[i], v);
      chk("readback", w, v);
      wr(regs[i], (regs[i] == 8'h1e) ? 8'he0 : 8'h00);
    end
    rd(8'h55, v);
    chk("unmapped", 8'h00, v);
    chk("ch_en", 8'h00, channel_en_o);
    wr(8'h14, 8'h80);
    step(2);
    chk("ch_en", 8'h01, channel_en_o);
    wr(8'h14, 8'h00);
    step(2);
    chk("ch_en", 8'h00, channel_en_o);
    c1 = 8'($urandom);
    wr(8'h3a, c1);
    wr(8'h2f, 8'h10);
    sig_detect_i = 1'b1;
    step(3);
    chk("div", 8'h03, vco_div_o);
    chk("boost", c1, boost_applied_o);
    rd(8'h03, v);
    chk("boost_reg", c1, v);
    adapt_boost_i = ~c1;
    pulse(adapt_done_i);
    chk("boost", c1, boost_applied_o);
    for (int i = 2; i >= 0; i--) begin
      pulse(lock_try_fail_i);
      chk("div", 8'(i), vco_div_o);
    end
    c2 = 8'($urandom);
    wr(8'h03, c2);
    step(1);
    chk("boost", c2, boost_applied_o);
    adapt_boost_i = ~c2;
    pulse(adapt_done_i);
    chk("boost", c2, boost_applied_o);
    wr(8'h31, 8'h20);
    adapt_boost_i = ~c2;
    pulse(adapt_done_i);
    chk("boost", ~c2, boost_applied_o);
    pulse(lock_try_fail_i);
    chk("div", 8'h03, vco_div_o);
    wr(8'h31, 8'h00);
    wr(8'h3a, c1);
    wr(8'h03, c1);
    wr(8'h40, c1);
    wr(8'h13, 8'h04);
    pulse(adapt_done_i);
    pulse(lock_try_fail_i);
    chk("boost", c1, boost_applied_o);
    chk("limit", 8'h01, stage_limit_o);
    sig_detect_i = 1'b0;
    c1 = 8'($urandom % 32);
    c2 = 8'($urandom % 32);
    wr(8'h08, c1);
    wr(8'h0b, c2);
    wr(8'h09, 8'h80);
    sig_detect_i = 1'b1;
    step(3);
    chk("cap", c1, cap_code_o);
    pulse(lock_try_fail_i);
    chk("cap", c2, cap_code_o);
    chk("div", 8'h00, vco_div_o);
    pulse(lock_try_fail_i);
    chk("cap", c1, cap_code_o);
    chk("div", 8'h03, vco_div_o);
    sig_detect_i = 1'b0;
    wr(8'h09, 8'h00);
    wr(8'h36, 8'h30);
    sig_detect_i = 1'b1;
    step(3);
    chk("search", 8'h01, cap_search_o);
    pulse(cap_search_done_i);
    chk("search", 8'h00, cap_search_o);
    chk("range", 8'h01, search_range_o);
    wr(8'h36, 8'h00);
    cdr_lock_i = 1'b1;
    step(4);
    chk("free_run", 8'h00, vco_free_run_o);
    // Sink held off: the buffer plus the output stage must take nine words.
    rt_valid_i = 1'b1;
    rt_data_i = 8'($urandom);
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (!rt_ready_o) break;
      exp_q.push_back(rt_data_i);
      #1 rt_data_i = 8'($urandom);
    end
    #1 rt_valid_i = 1'b0;
    chk("fill", 8'h09, 8'(n));
    stall = 1'b0;
    drain;
    raw_data_i = 8'($urandom);
    prbs_data_i = 8'($urandom);
    iclk_pat_i = 8'($urandom);
    qclk_pat_i = 8'($urandom);
    osc10_pat_i = 8'($urandom);
    cdr_lock_i = 1'b0;
    step(4);
    wr(8'h1e, 8'h40);
    push(2);
    wr(8'h1e, 8'ha0);
    push(7);
    wr(8'h1e, 8'he0);
    push(7);
    cdr_lock_i = 1'b1;
    step(4);
    wr(8'h1e, 8'h40);
    push(1);
    wr(8'h09, 8'h20);
    for (int s = 0; s < 8; s++) begin
      wr(8'h1e, 8'(s << 5));
      push(s);
    end
    wr(8'h09, 8'h30);
    wr(8'h1e, 8'h61);
    push(8);
    wr(8'h09, 8'h20);
    wr(8'h1e, 8'h00);
    wr(8'h3f, 8'h80);
    sig_detect_i = 1'b0;
    cdr_lock_i = 1'b0;
    step(3);
    chk("ch_en", 8'h01, channel_en_o);
    chk("free_run", 8'h01, vco_free_run_o);
    push(0);
    stop_test;
  end
endmodule
`default_nettype wire
